// ==== logic/sram_pkg.sv ====
// Constants and carriers for the pipelined burst static memory port.
// Assumes one clock domain; the test port clock is sampled as a data input.
package sram_pkg;

  // Variant select: 1 builds 256K x 36, 0 builds 512K x 18
  localparam bit WIDE        = 1'b1;
  localparam int DATA_W      = WIDE ? 36 : 18;
  localparam int LANE_W      = 9;  // Eight data bits plus one parity bit
  localparam int LANES       = DATA_W / LANE_W;
  localparam int ADDR_W      = WIDE ? 18 : 19;
  localparam int DEPTH       = 1 << ADDR_W;
  localparam int BURST_W     = 2;
  localparam int RD_LAT      = 2;  // Enabled cycles from command to read data
  localparam int WR_LAT      = 2;  // Enabled cycles from command to write data
  localparam int CLK_MHZ     = 50;

  // Test access port
  localparam int IR_W        = 3;
  localparam logic [IR_W-1:0] IR_IDCODE  = 3'h1;
  localparam logic [IR_W-1:0] IR_BYPASS  = 3'h7;
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
  localparam logic [31:0]     ID_CODE    = 32'h0000_0A01;  // Arbitrary value

  typedef logic [DATA_W-1:0]  word_t;
  typedef logic [ADDR_W-1:0]  addr_t;
  typedef logic [LANES-1:0]   lane_t;
  typedef logic [BURST_W-1:0] burst_t;

  // One decoded access
  typedef struct packed {
    logic  vld;
    logic  we;
    addr_t addr;
    lane_t lane_n;
  } cmd_s;

  // One write with its captured data
  typedef struct packed {
    logic  vld;
    addr_t addr;
    lane_t lane_n;
    word_t data;
  } wr_s;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_e;

endpackage : sram_pkg

// ==== logic/sram_array.sv ====
// Storage array with per-lane write strobes and a registered read port.
// Assumes the caller gives a clock enable that freezes both ports.
`timescale 1ns/1ps
module sram_array
  import sram_pkg::*;
(
  input  wire logic  i_mclk,
  input  wire logic  i_en,
  input  wire logic  i_wr,
  input  wire addr_t i_wr_addr,
  input  wire lane_t i_wr_lane_n,
  input  wire word_t i_wr_data,
  input  wire addr_t i_rd_addr,
  output word_t      o_rd_data
);

  word_t mem [DEPTH];

  // Byte lane writes, each lane gated by its own select
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    always_ff @(posedge i_mclk) begin
      if (i_en && i_wr && !i_wr_lane_n[g]) begin
        mem[i_wr_addr][g*LANE_W +: LANE_W] <= i_wr_data[g*LANE_W +: LANE_W];
      end
    end
  end

  // Registered read, old data on a same-edge write
  always_ff @(posedge i_mclk) begin
    if (i_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule : sram_array

// ==== logic/burst_sram_port.sv ====
// Host port of a pipelined burst static memory with a small test port.
// Assumes synchronous host inputs and a shared data bus resolved outside.
`timescale 1ns/1ps
module burst_sram_port
  import sram_pkg::*;
(
  input  wire logic  i_mclk,
  input  wire logic  i_srst,
  input  wire logic  i_ce,
  input  wire logic  i_clock_qualify_n,
  input  wire logic  i_chip_select_1_n,
  input  wire logic  i_chip_select_2,
  input  wire logic  i_chip_select_3_n,
  input  wire logic  i_write_n,
  input  wire logic  i_address_advance_load,
  input  wire addr_t i_addr,
  input  wire lane_t i_byte_lane_select_n,
  input  wire logic  i_burst_interleaved,
  input  wire logic  i_output_enable_n,
  input  wire logic  i_sleep_request,
  input  wire word_t i_dq,
  output word_t      o_dq,
  output logic       o_dq_oe,
  output logic       o_sleep_active,
  input  wire logic  i_tck,
  input  wire logic  i_tms,
  input  wire logic  i_tdi,
  output logic       o_tdo,
  output logic       o_tdo_oe
);

  logic       en;
  logic       sel_in_ff, we_in_ff, adv_in_ff, sleep_ff;
  addr_t      addr_in_ff;
  lane_t      lane_in_ff;
  addr_t      base_ff;
  burst_t     cnt_ff, cnt_nxt, boff;
  logic       last_vld_ff, last_we_ff;
  cmd_s       cmd, cmd1_ff, cmd2_ff;
  wr_s        wr_ff, last_wr_ff;
  word_t      mem_rd, byp1, byp2, byp3, dq_ff;
  logic       rd_vld_ff;

  // Both the qualifier and the enable must allow a cycle
  assign en = i_ce && !i_clock_qualify_n;

  // Input registers for address and control
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sel_in_ff  <= 1'b0;
      we_in_ff   <= 1'b0;
      adv_in_ff  <= 1'b0;
      sleep_ff   <= 1'b0;
      addr_in_ff <= '0;
      lane_in_ff <= '1;
    end else if (en) begin
      sel_in_ff  <= !i_chip_select_1_n && i_chip_select_2 &&
                    !i_chip_select_3_n;
      we_in_ff   <= !i_write_n;
      adv_in_ff  <= i_address_advance_load;
      sleep_ff   <= i_sleep_request;
      addr_in_ff <= i_addr;
      lane_in_ff <= i_byte_lane_select_n;
    end
  end

  assign o_sleep_active = sleep_ff;

  // Next burst offset, linear count or interleaved flip
  assign cnt_nxt = cnt_ff + 2'h1;
  assign boff    = i_burst_interleaved ? (base_ff[BURST_W-1:0] ^ cnt_nxt)
                 : BURST_W'(base_ff[BURST_W-1:0] + cnt_nxt);

  // Decode: advance continues the last access, else load a new one
  always_comb begin
    cmd.lane_n = lane_in_ff;
    if (adv_in_ff) begin
      cmd.vld  = last_vld_ff && !sleep_ff;
      cmd.we   = last_we_ff;
      cmd.addr = {base_ff[ADDR_W-1:BURST_W], boff};
    end else begin
      cmd.vld  = sel_in_ff && !sleep_ff;
      cmd.we   = we_in_ff;
      cmd.addr = addr_in_ff;
    end
  end

  // Burst base, counter and the access type being continued
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      base_ff     <= '0;
      cnt_ff      <= '0;
      last_vld_ff <= 1'b0;
      last_we_ff  <= 1'b0;
    end else if (en) begin
      if (!adv_in_ff) begin
        base_ff     <= addr_in_ff;
        cnt_ff      <= '0;
        last_vld_ff <= cmd.vld;
        last_we_ff  <= we_in_ff;
      end else begin
        cnt_ff      <= cnt_nxt;
        last_vld_ff <= cmd.vld;
      end
    end
  end

  // Access pipeline and write capture, one word per cycle
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cmd1_ff    <= '0;
      cmd2_ff    <= '0;
      wr_ff      <= '0;
      last_wr_ff <= '0;
    end else if (en) begin
      cmd1_ff    <= cmd;
      cmd2_ff    <= cmd1_ff;  // Write data shares the read data slot
      wr_ff.vld    <= cmd2_ff.vld && cmd2_ff.we;
      wr_ff.addr   <= cmd2_ff.addr;
      wr_ff.lane_n <= cmd2_ff.lane_n;
      wr_ff.data   <= i_dq;
      last_wr_ff <= wr_ff;
    end
  end

  // Storage array, written one cycle after data capture
  sram_array u_array (
    .i_mclk      (i_mclk),
    .i_en        (en),
    .i_wr        (wr_ff.vld),
    .i_wr_addr   (wr_ff.addr),
    .i_wr_lane_n (wr_ff.lane_n),
    .i_wr_data   (wr_ff.data),
    .i_rd_addr   (cmd.addr),
    .o_rd_data   (mem_rd)
  );

  // Forward writes not yet seen by the array, older first
  for (genvar g = 0; g < LANES; g++) begin : g_byp
    assign byp1[g*LANE_W +: LANE_W] =
      (last_wr_ff.vld && last_wr_ff.addr == cmd1_ff.addr &&
       !last_wr_ff.lane_n[g]) ? last_wr_ff.data[g*LANE_W +: LANE_W]
                              : mem_rd[g*LANE_W +: LANE_W];
    assign byp2[g*LANE_W +: LANE_W] =
      (wr_ff.vld && wr_ff.addr == cmd1_ff.addr && !wr_ff.lane_n[g])
        ? wr_ff.data[g*LANE_W +: LANE_W]
        : byp1[g*LANE_W +: LANE_W];
    assign byp3[g*LANE_W +: LANE_W] =
      (cmd2_ff.vld && cmd2_ff.we && cmd2_ff.addr == cmd1_ff.addr &&
       !cmd2_ff.lane_n[g]) ? i_dq[g*LANE_W +: LANE_W]  // Newest, on the bus
                           : byp2[g*LANE_W +: LANE_W];
  end

  // Output register and its driver enable
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      dq_ff     <= '0;
      rd_vld_ff <= 1'b0;
    end else if (en) begin
      rd_vld_ff <= cmd1_ff.vld && !cmd1_ff.we;
      if (cmd1_ff.vld && !cmd1_ff.we) begin
        dq_ff <= byp3;
      end
    end
  end

  assign o_dq    = dq_ff;
  assign o_dq_oe = rd_vld_ff && !i_output_enable_n;

  // Test port: clock sampled, edges found against last sample
  tap_state_e       tap_ff, tap_nxt;
  logic             tck_ff, tck_rise, tck_fall;
  logic [IR_W-1:0]  ir_ff, ir_sh_ff;
  logic [31:0]      dr_sh_ff;
  logic             tdo_ff, tdo_oe_ff;

  assign tck_rise = i_tck && !tck_ff;
  assign tck_fall = !i_tck && tck_ff;

  // Standard sixteen-state controller
  always_comb begin
    unique case (tap_ff)
      TLR:    tap_nxt = i_tms ? TLR    : RTI;
      RTI:    tap_nxt = i_tms ? SEL_DR : RTI;
      SEL_DR: tap_nxt = i_tms ? SEL_IR : CAP_DR;
      CAP_DR: tap_nxt = i_tms ? EX1_DR : SH_DR;
      SH_DR:  tap_nxt = i_tms ? EX1_DR : SH_DR;
      EX1_DR: tap_nxt = i_tms ? UPD_DR : PA_DR;
      PA_DR:  tap_nxt = i_tms ? EX2_DR : PA_DR;
      EX2_DR: tap_nxt = i_tms ? UPD_DR : SH_DR;
      UPD_DR: tap_nxt = i_tms ? SEL_DR : RTI;
      SEL_IR: tap_nxt = i_tms ? TLR    : CAP_IR;
      CAP_IR: tap_nxt = i_tms ? EX1_IR : SH_IR;
      SH_IR:  tap_nxt = i_tms ? EX1_IR : SH_IR;
      EX1_IR: tap_nxt = i_tms ? UPD_IR : PA_IR;
      PA_IR:  tap_nxt = i_tms ? EX2_IR : PA_IR;
      EX2_IR: tap_nxt = i_tms ? UPD_IR : SH_IR;
      UPD_IR: tap_nxt = i_tms ? SEL_DR : RTI;
    endcase
  end

  // Controller state and shift registers, moved on clock rise
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tck_ff   <= 1'b0;
      tap_ff   <= TLR;
      ir_ff    <= IR_IDCODE;
      ir_sh_ff <= '0;
      dr_sh_ff <= '0;
    end else if (en) begin
      tck_ff <= i_tck;
      if (tck_rise) begin
        tap_ff <= tap_nxt;
        unique case (tap_ff)
          TLR:     ir_ff    <= IR_IDCODE;
          CAP_IR:  ir_sh_ff <= IR_CAPTURE;
          SH_IR:   ir_sh_ff <= {i_tdi, ir_sh_ff[IR_W-1:1]};
          UPD_IR:  ir_ff    <= ir_sh_ff;
          CAP_DR:  dr_sh_ff <= (ir_ff == IR_IDCODE) ? ID_CODE : '0;
          SH_DR:   dr_sh_ff <= (ir_ff == IR_IDCODE)
                             ? {i_tdi, dr_sh_ff[31:1]} : {31'h0, i_tdi};
          default: ;
        endcase
      end
    end
  end

  // Serial output changes on clock fall, driven only while shifting
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tdo_ff    <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else if (en && tck_fall) begin
      tdo_ff    <= (tap_ff == SH_IR) ? ir_sh_ff[0] : dr_sh_ff[0];
      tdo_oe_ff <= (tap_ff == SH_IR) || (tap_ff == SH_DR);
    end
  end

  assign o_tdo    = tdo_ff;
  assign o_tdo_oe = tdo_oe_ff;

  // Checks on the access pipeline and the test port
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  sequence s_rd;
    en && cmd.vld && !cmd.we;
  endsequence

  input_to_data_a: assert property (
    (en && !i_chip_select_1_n && i_chip_select_2 && !i_chip_select_3_n &&
     !i_address_advance_load && i_write_n && !i_sleep_request)
    ##1 en ##1 en |=> rd_vld_ff) else $error("read data late");
  deselect_quiet_a: assert property (
    (en && i_chip_select_2 == 1'b0 && !i_address_advance_load)
    ##1 en ##1 en |=> !rd_vld_ff) else $error("deselected access drove");
  write_phase_off_a: assert property (
    (en && cmd.vld && cmd.we) ##1 en |=> !o_dq_oe)
    else $error("drivers on during write data");
  back_to_back_a: assert property (
    s_rd ##1 s_rd ##1 en |-> rd_vld_ff ##1 rd_vld_ff)
    else $error("read stream broken");
  freeze_a: assert property (
    !en |=> $stable(dq_ff) && $stable(cmd1_ff) && $stable(wr_ff) &&
    $stable(base_ff) && $stable(tap_ff)) else $error("state moved frozen");
  lane_forward_a: assert property (
    (en && cmd1_ff.vld && !cmd1_ff.we && cmd2_ff.vld && cmd2_ff.we &&
     !cmd2_ff.lane_n[0] && cmd2_ff.addr == cmd1_ff.addr)
    |=> dq_ff[LANE_W-1:0] == $past(i_dq[LANE_W-1:0]))
    else $error("byte lane not forwarded");
  drive_enable_a: assert property (
    o_dq_oe == (rd_vld_ff && !i_output_enable_n))
    else $error("driver enable wrong");
  burst_order_a: assert property (
    (adv_in_ff && !i_burst_interleaved) |->
    cmd.addr[BURST_W-1:0] == BURST_W'(base_ff[BURST_W-1:0] + cnt_ff + 2'h1))
    else $error("linear burst order wrong");
  sleep_idle_a: assert property (
    (en && i_sleep_request) |=> !cmd.vld ##1 (!en || !cmd1_ff.vld))
    else $error("access during sleep");
  tap_reset_a: assert property (
    (en && tck_rise && tap_ff == TLR) |=> ir_ff == IR_IDCODE)
    else $error("instruction not reset");

  cover_read_c:   cover property (s_rd ##1 en ##1 en ##1 o_dq_oe);
  cover_write_c:  cover property (en && wr_ff.vld);
  cover_burst_c:  cover property (en && adv_in_ff && cmd.vld);
  cover_bypass_c: cover property (en && cmd1_ff.vld && !cmd1_ff.we &&
                                  wr_ff.vld && wr_ff.addr == cmd1_ff.addr);

endmodule : burst_sram_port

// ==== bench/host_ctrl_model.sv ====
// Host controller model: command pins and delayed write data.
// Assumes its tasks are called by the bench, each waiting for an edge.
`timescale 1ns/1ps
module host_ctrl_model
  import sram_pkg::*;
(
  input  wire logic  i_mclk,
  output logic       o_ce,
  output logic       o_cq_n,
  output logic [2:0] o_sel,
  output logic       o_we_n,
  output logic       o_adv,
  output addr_t      o_addr,
  output lane_t      o_lane_n,
  output word_t      o_dq
);
  logic  wv0, wv1, wv2, wv3;
  word_t wd0, wd1, wd2, wd3;

  // Idle, deselected, running
  initial begin
    {o_ce, o_cq_n, o_sel, o_we_n, o_adv} = 7'h56;
    {o_addr, o_lane_n, o_dq, wv0, wv1, wv2, wd0} = '0;
  end

  // Write word in the read data slot of its command, else a moving pattern
  always @(posedge i_mclk) begin
    if (o_ce & !o_cq_n) begin
      {wv3, wd3, wv2, wd2, wv1, wd1} <= {wv2, wd2, wv1, wd1, wv0, wd0};
      wv0 <= 1'b0;
    end
    #1 o_dq = wv3 ? wd3 : ~o_dq;
  end

  // One bus cycle; burst beats show a wrong address on purpose
  task automatic cyc(input logic [2:0] s, input logic we, adv,
                     input addr_t a, input lane_t ln, input word_t d);
    @(posedge i_mclk);
    #1;
    o_sel = s;
    o_we_n = !we;
    o_adv = adv;
    o_addr = adv ? ~a : a;
    o_lane_n = ln;
    wv0 = (s == 3'h2) & we;
    wd0 = d;
  endtask : cyc

  // Freezes the port for n edges by qualifier or by enable
  task automatic stall(input int n, input logic by_ce);
    @(posedge i_mclk);
    #1;
    o_sel = 3'h5;
    o_adv = 1'b0;
    if (by_ce) o_ce = 1'b0;
    else o_cq_n = 1'b1;
    repeat (n) @(posedge i_mclk);
    #1;
    {o_ce, o_cq_n} = 2'b10;
  endtask : stall
endmodule : host_ctrl_model

// ==== bench/burst_sram_port_tb.sv ====
// Self-checking bench for the burst memory port.
// Assumes the wide variant; the host model owns the command pins.
`timescale 1ns/1ps
module burst_sram_port_tb
  import sram_pkg::*;
;
  typedef struct packed {logic rd; word_t d;} exp_s;
  logic       mclk, srst, ce, cq_n, we_n, adv, ilv, oe_n, slp;
  logic       tck, tms, tdi, dq_oe, slp_act, tdo, tdo_oe, b;
  logic [2:0] sel;
  addr_t      addr;
  lane_t      ln_n;
  word_t      dq_in, dq_out;
  exp_s       e0, e1, e2, e3;
  word_t      mem [addr_t];
  int         mismatches, checks_done, cyc_n;
  wire        en = ce & !cq_n;

  host_ctrl_model u_host_ctrl_model (.i_mclk(mclk), .o_ce(ce),
    .o_cq_n(cq_n), .o_sel(sel), .o_we_n(we_n), .o_adv(adv),
    .o_addr(addr), .o_lane_n(ln_n), .o_dq(dq_in));
  burst_sram_port u_burst_sram_port (.i_mclk(mclk), .i_srst(srst),
    .i_ce(ce), .i_clock_qualify_n(cq_n), .i_chip_select_1_n(sel[2]),
    .i_chip_select_2(sel[1]), .i_chip_select_3_n(sel[0]),
    .i_write_n(we_n), .i_address_advance_load(adv), .i_addr(addr),
    .i_byte_lane_select_n(ln_n), .i_burst_interleaved(ilv),
    .i_output_enable_n(oe_n), .i_sleep_request(slp), .i_dq(dq_in),
    .o_dq(dq_out), .o_dq_oe(dq_oe), .o_sleep_active(slp_act),
    .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo),
    .o_tdo_oe(tdo_oe));

  // Clock, 20 ns period
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Hang guard
  always @(posedge mclk) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      mismatches++;
      complete_run();
    end
  end

  // Expected read pipeline, judged every cycle
  always @(posedge mclk) begin
    if (srst) {e1, e2, e3} <= '0;
    else if (en) {e3, e2, e1} <= {e2, e1, e0};
    if (en) e0 <= '0;
    #2;
    chk(dq_oe === (e3.rd & !oe_n), "drive enable");
    if (e3.rd & !oe_n) chk(dq_out === e3.d, "read word");
  end

  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  // One access; reference memory and expectation follow it
  task automatic op(input logic [2:0] s, input logic we, adv,
                    input addr_t a, input lane_t ln, input word_t d);
    u_host_ctrl_model.cyc(s, we, adv, a, ln, d);
    if (s == 3'h2 && !slp) begin
      for (int k = 0; k < LANES; k++)
        if (we && !ln[k])
          mem[a][k*LANE_W+:LANE_W] = d[k*LANE_W+:LANE_W];
      if (!we) e0 = {1'b1, mem[a]};
    end
  endtask : op

  task automatic idle(input int n);
    repeat (n) op(3'h5, 0, 0, '0, '0, '0);
  endtask : idle

  function automatic addr_t nxt(addr_t a, int i);
    logic [1:0] c;
    c = ilv ? a[1:0] ^ i[1:0] : a[1:0] + i[1:0];
    return {a[ADDR_W-1:2], c};
  endfunction : nxt

  // One test clock period, sampling the serial output before the rise
  task automatic tk(input logic m, output logic o);
    tms = m;
    repeat (4) @(posedge mclk);
    #1 o = tdo;
    tck = 1'b1;
    repeat (4) @(posedge mclk);
    #1 tck = 1'b0;
  endtask : tk

  task automatic t_mix;
    op(3'h2, 1, 0, 18'h10, '0, 36'h1_2345_6789);
    op(3'h2, 1, 0, '1, '0, 36'hF_0F0F_0F0F);
    op(3'h2, 0, 0, 18'h10, '0, '0);
    op(3'h2, 1, 0, 18'h20, '0, 36'hA_BCDE_F012);
    op(3'h2, 0, 0, 18'h20, '0, '0);
    op(3'h2, 0, 0, '1, '0, '0);
    idle(3);
    op(3'h2, 1, 0, 18'h30, '0, 36'h1_1111_1111);
    op(3'h2, 1, 0, 18'h30, 4'h5, 36'hE_EEEE_EEEE);
    op(3'h2, 0, 0, 18'h30, '0, '0);
    op(3'h2, 1, 0, 18'h30, 4'hE, 36'h0);
    op(3'h2, 0, 0, 18'h30, '0, '0);
    idle(3);
    $display("test mix done");
  endtask : t_mix

  task automatic t_burst;
    for (int m = 0; m < 2; m++) begin
      ilv = m[0];
      for (int j = 0; j < 12; j++)
        op(3'h2, j < 4, j % 4 != 0 && (j < 4 || j > 7),
           nxt(18'h41, j % 4), '0, word_t'(16 * m + j));
      idle(3);
    end
    $display("test burst done");
  endtask : t_burst

  task automatic t_ctrl;
    op(3'h2, 1, 0, 18'h50, '0, 36'h7_7777_7777);
    u_host_ctrl_model.stall(3, 0);
    op(3'h2, 0, 0, 18'h50, '0, '0);
    idle(2);
    u_host_ctrl_model.stall(2, 1);
    for (int k = 0; k < 3; k++)
      op(3'h2 ^ (3'h4 >> k), 0, 0, 18'h10, '0, '0);
    op(3'h2, 0, 0, 18'h10, '0, '0);
    op(3'h2, 0, 0, 18'h20, '0, '0);
    idle(2);
    oe_n = 1'b1;
    idle(1);
    oe_n = 1'b0;
    idle(2);
    $display("test control done");
  endtask : t_ctrl

  task automatic t_sleep;
    slp = 1'b1;
    op(3'h2, 1, 0, 18'h10, '0, 36'hD_DDDD_DDDD);
    op(3'h2, 0, 0, 18'h10, '0, '0);
    idle(3);
    chk(slp_act === 1'b1, "sleep flag");
    slp = 1'b0;
    idle(1);
    op(3'h2, 0, 0, 18'h10, '0, '0);
    idle(3);
    chk(slp_act === 1'b0, "wake flag");
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_tap;
    logic [31:0] id;
    for (int i = 0; i < 9; i++)
      tk(i < 5 || i == 6, b);
    for (int i = 0; i < 32; i++) begin
      tk(i == 31, id[i]);
      if (i == 0) chk(tdo_oe === 1'b1, "scan drive");
    end
    chk(id === ID_CODE, "identity");
    $display("test scan done");
  endtask : t_tap

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  // Reset for three cycles, then the tests in turn
  initial begin
    {srst, ilv, oe_n, slp, tck, tms, tdi} = 7'h40;
    repeat (3) @(posedge mclk);
    #1 srst = 1'b0;
    t_mix();
    t_burst();
    t_ctrl();
    t_sleep();
    t_tap();
    complete_run();
  end
endmodule : burst_sram_port_tb
